//--- include/ces_pkg.sv
// shared constants for the can error and status reporting block
package ces_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte offsets on the wishbone bus)
  localparam int ADDR_W = 5;
  localparam logic [4:0] CTRL_OFS = 5'h00; // control register
  localparam logic [4:0] STAT_OFS = 5'h04; // status register
  localparam logic [4:0] ERRC_OFS = 5'h08; // error counters, read only
  localparam logic [4:0] IID_OFS = 5'h10; // interrupt identifier, read only

  // control register fields
  localparam int CTRL_INIT = 0; // initialisation, stops bus activity
  localparam int CTRL_IE = 1; // module interrupt enable
  localparam int CTRL_SIE = 2; // status_change_irq_enable
  localparam int CTRL_EIE = 3; // error_irq_enable
  localparam logic [3:0] CTRL_RST = 4'h1;

  // status register fields
  localparam int STAT_LEC_LSB = 0; // last_fault_code [2:0]
  localparam int STAT_TX_SUCCESS_FLAG = 3; // tx_success_flag
  localparam int STAT_RX_SUCCESS_FLAG = 4; // rx_success_flag
  localparam int STAT_PASSIVE_STATE_FLAG = 5; // passive_state_flag
  localparam int STAT_WARNING_LEVEL_FLAG = 6; // warning_level_flag
  localparam int STAT_BUS_OFF_FLAG = 7; // bus_off_flag
  localparam logic [7:0] STAT_RST = 8'h00;

  // error counter register fields
  localparam int ERRC_TEC_LSB = 0; // tx_fault_count [7:0]
  localparam int ERRC_REC_LSB = 8; // rx_fault_count [14:8]
  localparam int ERRC_RP = 15; // receive_passive_flag
  localparam logic [31:0] ERRC_RST = 32'h0000_0000;

  // interrupt identifier of the status interrupt
  localparam logic [15:0] STATUS_INT_ID = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // last fault codes
  localparam logic [2:0] LEC_NONE = 3'h0;
  localparam logic [2:0] LEC_STUFF = 3'h1;
  localparam logic [2:0] LEC_FORM = 3'h2;
  localparam logic [2:0] LEC_ACK = 3'h3;
  localparam logic [2:0] LEC_RECESSIVE_MISS = 3'h4;
  localparam logic [2:0] LEC_DOMINANT_MISS = 3'h5;
  localparam logic [2:0] LEC_CRC = 3'h6;
  localparam logic [2:0] LEC_UNUSED = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // fault confinement limits
  localparam logic [7:0] WARN_LIMIT = 8'h60; // 96
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80; // 128
  localparam logic [7:0] REC_RETURN = 8'h77; // 119 after rx in passive
  localparam logic [8:0] TX_STEP = 9'h008; // tx error weight
  localparam int RECOVERY_RUNS = 129; // idle runs to leave bus-off

  // fault confinement state
  typedef enum {CONF_ACTIVE, CONF_PASSIVE, CONF_BUS_OFF} ces_conf_type;

endpackage : ces_pkg

//--- rtl/ces_fault_counters.sv
// transmit and receive fault counters with confinement state
`timescale 1ns/1ps
module ces_fault_counters #(
  parameter int RUNS = ces_pkg::RECOVERY_RUNS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tx_fault, // fault seen while transmitting
  input wire logic rx_fault, // fault seen while receiving
  input wire logic tx_done, // error free transmission
  input wire logic rx_done, // error free reception
  input wire logic idle_run, // eleven recessive bits seen
  input wire logic recover_en, // init released by software
  output logic [7:0] tx_fault_count,
  output logic [7:0] rx_fault_count,
  output logic warn,
  output logic passive,
  output logic rx_passive,
  output logic bus_off
);

  ces_pkg::ces_conf_type conf_ff, nxt_conf; // confinement state
  logic [7:0] tec_ff, nxt_tec; // transmit counter
  logic [7:0] rec_ff, nxt_rec; // receive counter, capped at 128
  logic [7:0] runs_ff, nxt_runs; // idle runs seen in recovery
  logic [8:0] tec_sum; // widened to catch overflow past 255

  ////////////////////////////////////////////////////////////////////////////
  // next counter values
  always_comb
  begin
    nxt_tec = tec_ff;
    nxt_rec = rec_ff;
    nxt_runs = runs_ff;
    nxt_conf = conf_ff;
    tec_sum = {1'b0, tec_ff} + ces_pkg::TX_STEP;
    case (conf_ff)
      ces_pkg::CONF_BUS_OFF:
      begin
        // counters only restart after the full idle sequence
        if (recover_en && idle_run)
        begin
          if (runs_ff == 8'(RUNS - 1))
          begin
            nxt_tec = 8'h00;
            nxt_rec = 8'h00;
            nxt_runs = 8'h00;
            nxt_conf = ces_pkg::CONF_ACTIVE;
          end
          else
          begin
            nxt_runs = runs_ff + 8'h01;
          end
        end
      end
      default:
      begin
        // transmit counter: heavy weight up, one down
        if (tx_fault)
        begin
          if (tec_sum[8])
          begin
            nxt_tec = 8'hff;
          end
          else
          begin
            nxt_tec = tec_sum[7:0];
          end
        end
        else if (tx_done && tec_ff != 8'h00)
        begin
          nxt_tec = tec_ff - 8'h01;
        end
        // receive counter: passive nodes fall back on success
        if (rx_fault && rec_ff < ces_pkg::PASSIVE_LIMIT)
        begin
          nxt_rec = rec_ff + 8'h01;
        end
        else if (rx_done && rec_ff >= ces_pkg::PASSIVE_LIMIT)
        begin
          nxt_rec = ces_pkg::REC_RETURN;
        end
        else if (rx_done && rec_ff != 8'h00)
        begin
          nxt_rec = rec_ff - 8'h01;
        end
        // derive the state from the new counts
        if (tx_fault && tec_sum[8])
        begin
          nxt_conf = ces_pkg::CONF_BUS_OFF;
          nxt_runs = 8'h00;
        end
        else if (nxt_tec >= ces_pkg::PASSIVE_LIMIT ||
                 nxt_rec >= ces_pkg::PASSIVE_LIMIT)
        begin
          nxt_conf = ces_pkg::CONF_PASSIVE;
        end
        else
        begin
          nxt_conf = ces_pkg::CONF_ACTIVE;
        end
      end
    endcase
  end

  // register the counters
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conf_ff <= ces_pkg::CONF_ACTIVE;
      tec_ff <= 8'h00;
      rec_ff <= 8'h00;
      runs_ff <= 8'h00;
    end
    else
    begin
      conf_ff <= nxt_conf;
      tec_ff <= nxt_tec;
      rec_ff <= nxt_rec;
      runs_ff <= nxt_runs;
    end
  end

  // flags follow the counters and the confinement state directly
  assign tx_fault_count = tec_ff;
  assign rx_fault_count = rec_ff;
  assign bus_off = (conf_ff == ces_pkg::CONF_BUS_OFF);
  assign passive = (conf_ff == ces_pkg::CONF_PASSIVE);
  assign rx_passive = (rec_ff >= ces_pkg::PASSIVE_LIMIT);
  assign warn = (tec_ff >= ces_pkg::WARN_LIMIT) ||
                (rec_ff >= ces_pkg::WARN_LIMIT);

endmodule : ces_fault_counters

//--- rtl/ces_status_top.sv
// can error classification, status register and error counter register
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ces_status_top #(
  parameter int RUNS = ces_pkg::RECOVERY_RUNS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ces_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stuff_err, // protocol core pulses, same clock
  input wire logic form_err,
  input wire logic ack_err,
  input wire logic recessive_miss_error,
  input wire logic dominant_miss_error,
  input wire logic crc_err,
  input wire logic tx_active, // core is transmitter of current frame
  input wire logic rx_done,
  input wire logic tx_done,
  input wire logic idle_run,
  output logic init_o, // stops the protocol core
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address match, shared by read and write decode
  function automatic logic hit(
    input logic [ces_pkg::ADDR_W-1:0] adr,
    input logic [4:0] ofs
  );
    hit = (adr == ofs);
  endfunction : hit

  // lowest event index wins when several errors coincide
  function automatic logic [2:0] lec_of(input logic [5:0] vec);
    logic [2:0] code;
    code = ces_pkg::LEC_NONE;
    for (int i = 5; i >= 0; i--)
    begin
      if (vec[i])
      begin
        code = 3'(i + 1);
      end
    end
    lec_of = code;
  endfunction : lec_of

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [5:0] err_vec; // stuff, form, ack, rec miss, dom miss, crc
  logic hw_err; // any classified bus error
  logic run_hit; // idle run while recovering from bus-off
  logic hw_upd; // hardware update of lec, rx or tx flag
  logic flag_chg; // bus-off or warning flag moved
  logic req, wr, rd; // bus request decode
  logic stat_wr, stat_rd; // status register accesses
  logic [31:0] rd_word; // read mux
  logic [31:0] errc_word; // error counter register image
  logic [7:0] tx_fault_count, rx_fault_count; // counters from the confinement unit
  logic warn, passive, rx_passive, bus_off;
  logic ack_ff, nxt_ack; // bus answer
  logic [31:0] dat_ff, nxt_dat; // read data
  logic [3:0] ctrl_ff, nxt_ctrl; // init, ie, sie, eie
  logic [2:0] lec_ff, nxt_lec; // last_fault_code
  logic rx_success_flag_ff, nxt_rx_success_flag; // rx_success_flag
  logic tx_success_flag_ff, nxt_tx_success_flag; // tx_success_flag
  logic bus_off_flag_ff, nxt_bus_off_flag; // bus_off_flag as last reported
  logic warning_level_flag_ff, nxt_warning_level_flag; // warning_level_flag as last reported
  logic passive_state_flag_ff, nxt_passive_state_flag; // passive_state_flag
  logic pend_ff, nxt_pend; // status interrupt pending
  logic irq_ff, nxt_irq; // interrupt line

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // fault confinement counters

  assign err_vec = {crc_err, dominant_miss_error, recessive_miss_error,
                    ack_err, form_err, stuff_err};
  assign hw_err = |err_vec;

  ces_fault_counters #(
    .RUNS(RUNS)
  ) u_counters (
    .clk(clk),
    .sys_rst(sys_rst),
    .tx_fault(hw_err && tx_active),
    .rx_fault(hw_err && !tx_active),
    .tx_done(tx_done),
    .rx_done(rx_done),
    .idle_run(idle_run),
    .recover_en(!ctrl_ff[ces_pkg::CTRL_INIT]),
    .tx_fault_count(tx_fault_count),
    .rx_fault_count(rx_fault_count),
    .warn(warn),
    .passive(passive),
    .rx_passive(rx_passive),
    .bus_off(bus_off)
  );

  // counter image; low seven bits of rec with the passive flag above
  assign errc_word = {16'h0000, rx_passive, rx_fault_count[6:0], tx_fault_count};

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait cycle, ack for one cycle, all offsets answer

  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign stat_wr = wr && hit(wb_adr_i, ces_pkg::STAT_OFS) && wb_sel_i[0];
  assign stat_rd = rd && hit(wb_adr_i, ces_pkg::STAT_OFS);

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit(wb_adr_i, ces_pkg::CTRL_OFS))
    begin
      rd_word = {28'h0000000, ctrl_ff};
    end
    else if (hit(wb_adr_i, ces_pkg::STAT_OFS))
    begin
      rd_word = {24'h000000, bus_off_flag_ff, warning_level_flag_ff, passive_state_flag_ff, rx_success_flag_ff, tx_success_flag_ff,
                 lec_ff};
    end
    else if (hit(wb_adr_i, ces_pkg::ERRC_OFS))
    begin
      rd_word = errc_word;
    end
    else if (hit(wb_adr_i, ces_pkg::IID_OFS))
    begin
      rd_word = {16'h0000, pend_ff ? ces_pkg::STATUS_INT_ID : 16'h0000};
    end
  end

  // next values of the bus group
  always_comb
  begin
    nxt_ack = req;
    nxt_dat = rd ? rd_word : dat_ff;
    nxt_ctrl = ctrl_ff;
    // writes to the counter offset fall through untouched
    if (wr && hit(wb_adr_i, ces_pkg::CTRL_OFS) && wb_sel_i[0])
    begin
      nxt_ctrl = wb_dat_i[3:0];
    end
    // entering bus-off forces init so software must restart the core
    if (bus_off && !bus_off_flag_ff)
    begin
      nxt_ctrl[ces_pkg::CTRL_INIT] = 1'b1;
    end
  end

  // register the bus group
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      ctrl_ff <= ces_pkg::CTRL_RST;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign init_o = ctrl_ff[ces_pkg::CTRL_INIT];

  ////////////////////////////////////////////////////////////////////////////
  // status register and status interrupt

  // idle runs only count while recovering, not in normal traffic
  assign run_hit = idle_run && bus_off && !ctrl_ff[ces_pkg::CTRL_INIT];
  assign hw_upd = hw_err || run_hit || rx_done || tx_done;
  assign flag_chg = (bus_off != bus_off_flag_ff) || (warn != warning_level_flag_ff);

  // next values of the status group
  always_comb
  begin
    nxt_lec = lec_ff;
    nxt_rx_success_flag = rx_success_flag_ff;
    nxt_tx_success_flag = tx_success_flag_ff;
    // software writes first, so a same-cycle hardware event wins
    if (stat_wr)
    begin
      nxt_lec = wb_dat_i[2:0];
      nxt_rx_success_flag = wb_dat_i[ces_pkg::STAT_RX_SUCCESS_FLAG];
      nxt_tx_success_flag = wb_dat_i[ces_pkg::STAT_TX_SUCCESS_FLAG];
    end
    if (hw_err)
    begin
      nxt_lec = lec_of(err_vec);
    end
    else if (run_hit)
    begin
      nxt_lec = ces_pkg::LEC_DOMINANT_MISS;
    end
    else if (rx_done || tx_done)
    begin
      nxt_lec = ces_pkg::LEC_NONE;
    end
    if (rx_done)
    begin
      nxt_rx_success_flag = 1'b1;
    end
    if (tx_done)
    begin
      nxt_tx_success_flag = 1'b1;
    end
    nxt_bus_off_flag = bus_off;
    nxt_warning_level_flag = warn;
    nxt_passive_state_flag = passive;
    // passive changes and software writes are left out on purpose
    nxt_pend = (pend_ff && !stat_rd) ||
               (ctrl_ff[ces_pkg::CTRL_EIE] && flag_chg) ||
               (ctrl_ff[ces_pkg::CTRL_SIE] && hw_upd);
    nxt_irq = nxt_pend && nxt_ctrl[ces_pkg::CTRL_IE];
  end

  // register the status group
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lec_ff <= ces_pkg::STAT_RST[2:0];
      rx_success_flag_ff <= 1'b0;
      tx_success_flag_ff <= 1'b0;
      bus_off_flag_ff <= 1'b0;
      warning_level_flag_ff <= 1'b0;
      passive_state_flag_ff <= 1'b0;
      pend_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      lec_ff <= nxt_lec;
      rx_success_flag_ff <= nxt_rx_success_flag;
      tx_success_flag_ff <= nxt_tx_success_flag;
      bus_off_flag_ff <= nxt_bus_off_flag;
      warning_level_flag_ff <= nxt_warning_level_flag;
      passive_state_flag_ff <= nxt_passive_state_flag;
      pend_ff <= nxt_pend;
      irq_ff <= nxt_irq;
    end
  end

  assign irq_o = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a single error event with no other error and no recovery run in the same cycle
  sequence solo_err(int idx);
    err_vec == (6'h01 << idx) && !run_hit;
  endsequence

  // a status read that the slave takes with no new cause
  sequence stat_read_quiet;
    stat_rd && !(ctrl_ff[ces_pkg::CTRL_EIE] && flag_chg) &&
    !(ctrl_ff[ces_pkg::CTRL_SIE] && hw_upd);
  endsequence

  lec_stuff_a: assert property (solo_err(0) |=> lec_ff == 3'h1)
    else $error("stuff error not recorded");
  lec_form_a: assert property (solo_err(1) |=> lec_ff == 3'h2)
    else $error("form error not recorded");
  lec_ack_a: assert property (solo_err(2) |=> lec_ff == 3'h3)
    else $error("ack error not recorded");
  lec_recmiss_a: assert property (solo_err(3) |=> lec_ff == 3'h4)
    else $error("recessive miss not recorded");
  lec_dommiss_a: assert property (solo_err(4) |=> lec_ff == 3'h5)
    else $error("dominant miss not recorded");
  lec_crc_a: assert property (solo_err(5) |=> lec_ff == 3'h6)
    else $error("checksum error not recorded");
  idle_run_a: assert property (!hw_err && run_hit |=> lec_ff == 3'h5)
    else $error("recovery run not reported");
  lec_hold_a: assert property (lec_ff == 3'h7 && !hw_upd && !stat_wr
    |=> lec_ff == 3'h7)
    else $error("unused code changed without event");
  err_irq_a: assert property (ctrl_ff[3] && flag_chg |=> pend_ff)
    else $error("flag change did not pend");
  stat_irq_a: assert property (ctrl_ff[2] && hw_upd |=> pend_ff)
    else $error("status update did not pend");
  no_irq_a: assert property (!pend_ff && !hw_upd && !flag_chg
    |=> !pend_ff)
    else $error("interrupt pended without cause");
  read_clear_a: assert property (stat_read_quiet |=>
    !pend_ff && !irq_o)
    else $error("status read did not clear pending");
  rp_flag_a: assert property (errc_word[15] ==
    (u_counters.rec_ff >= 8'h80))
    else $error("receive passive flag wrong");
  ok_clear_a: assert property (!rx_done && !stat_wr && rx_success_flag_ff
    |=> rx_success_flag_ff)
    else $error("success flag cleared by hardware");
  done_clear_a: assert property (!hw_err && !run_hit && tx_done
    |=> lec_ff == 3'h0)
    else $error("clean transfer did not clear code");
  ro_errc_a: assert property (wr && hit(wb_adr_i, 5'h08) && !hw_err
    && !rx_done && !tx_done && !idle_run |=> $stable(errc_word))
    else $error("counter register changed by write");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

endmodule : ces_status_top

//--- dv/ces_bus_node_model.sv
// partner model: protocol core and far nodes as a source of bus events
`timescale 1ns/1ps
module ces_bus_node_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] ev_code, // 1..6 fault, 8 rx, 9 tx, 10 idle
  input wire logic ev_go,
  output logic stuff_err,
  output logic form_err,
  output logic ack_err,
  output logic recessive_miss_error,
  output logic dominant_miss_error,
  output logic crc_err,
  output logic rx_done,
  output logic tx_done,
  output logic idle_run
);
  logic [3:0] ev_ff; // event of the current bit slot
  logic [3:0] nxt_ev_ff;
  //////////////////////////////////////////////////////////////////////////
  // only a commanded event, so a pulse never lasts past one slot
  always_comb
  begin
    nxt_ev_ff = ev_go ? ev_code : 4'h0;
  end
  // event register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ev_ff <= 4'h0;
    else
      ev_ff <= nxt_ev_ff;
  end
  //////////////////////////////////////////////////////////////////////////
  // one line per slot: no coincident faults from this model
  assign stuff_err = (ev_ff == 4'h1);
  assign form_err = (ev_ff == 4'h2);
  assign ack_err = (ev_ff == 4'h3);
  assign recessive_miss_error = (ev_ff == 4'h4);
  assign dominant_miss_error = (ev_ff == 4'h5);
  assign crc_err = (ev_ff == 4'h6);
  assign rx_done = (ev_ff == 4'h8);
  assign tx_done = (ev_ff == 4'h9);
  assign idle_run = (ev_ff == 4'ha);
endmodule : ces_bus_node_model

//--- dv/can_error_status_reporting_tb_top.sv
// testbench for the can error and status reporting block
`timescale 1ns/1ps
module can_error_status_reporting_tb_top;
  // event code, transmitter role, expected last fault code
  typedef struct packed {
    logic [3:0] ev;
    logic tx;
    logic [2:0] last_fault_code;
  } ces_row_type;
  logic clk, sys_rst, cyc, stb, we, tx_act, go;
  logic [4:0] adr;
  logic [3:0] sel, code;
  logic [3:0] wsel; // byte lanes for the next bus cycle
  logic [31:0] dat, q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, init_o, irq_o;
  logic se, fe, ae, rme, dme, ce, rxd, txd, idl;
  int fails, compares, tx_fault_count, rx_fault_count;
  ces_row_type rows [6];
  //////////////////////////////////////////////////////////////////////////
  ces_status_top #(.RUNS(3)) DUT (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stuff_err(se), .form_err(fe), .ack_err(ae),
    .recessive_miss_error(rme), .dominant_miss_error(dme), .crc_err(ce),
    .tx_active(tx_act), .rx_done(rxd), .tx_done(txd), .idle_run(idl),
    .init_o(init_o), .irq_o(irq_o));
  ces_bus_node_model node (.clk(clk), .sys_rst(sys_rst), .ev_code(code),
    .ev_go(go), .stuff_err(se), .form_err(fe), .ack_err(ae),
    .recessive_miss_error(rme), .dominant_miss_error(dme), .crc_err(ce),
    .rx_done(rxd), .tx_done(txd), .idle_run(idl));
  //////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // classic cycle; ack read before this edge's updates land
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    // no cycle budget here; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // one bus event, then time for counters and flags to settle
  task automatic ev(input logic [3:0] c);
    @(posedge clk);
    code <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : ev
  function automatic logic [31:0] errc(input int t, input int r);
    errc = {16'h0, (r >= 128) ? 1'b1 : 1'b0, 7'(r), 8'(t)};
  endfunction : errc
  task automatic final_report;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {cyc, stb, we, tx_act, go, adr, sel, code, dat} = '0;
    fails = 0;
    compares = 0;
    wsel = 4'hf;
    tx_fault_count = 0;
    rx_fault_count = 0;
    sys_rst = 1'b1;
    rows = '{'{4'h1, 1'b0, ces_pkg::LEC_STUFF},
             '{4'h2, 1'b0, ces_pkg::LEC_FORM},
             '{4'h3, 1'b1, ces_pkg::LEC_ACK},
             '{4'h4, 1'b1, ces_pkg::LEC_RECESSIVE_MISS},
             '{4'h5, 1'b1, ces_pkg::LEC_DOMINANT_MISS},
             '{4'h6, 1'b0, ces_pkg::LEC_CRC}};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, unmapped place reads zero
    rd(ces_pkg::CTRL_OFS, {28'h0, ces_pkg::CTRL_RST});
    rd(ces_pkg::STAT_OFS, 32'h0);
    rd(ces_pkg::ERRC_OFS, ces_pkg::ERRC_RST);
    rd(ces_pkg::IID_OFS, 32'h0);
    rd(5'h1c, 32'h0);
    $display("test reset done");
    // status change irq on, init released
    wb(1'b1, ces_pkg::CTRL_OFS, 32'h6);
    foreach (rows[i])
    begin
      tx_act <= rows[i].tx;
      ev(rows[i].ev);
      if (rows[i].tx)
        tx_fault_count += 8;
      else
        rx_fault_count += 1;
      chk({31'h0, irq_o}, 32'h1);
      rd(ces_pkg::IID_OFS, 32'h8000);
      rd(ces_pkg::STAT_OFS, {29'h0, rows[i].last_fault_code});
      repeat (2) @(posedge clk);
      chk({31'h0, irq_o}, 32'h0);
      rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, rx_fault_count));
    end
    $display("test codes done");
    // written 7 holds, write raises nothing, success clears the code
    wb(1'b1, ces_pkg::STAT_OFS, 32'h7);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_o}, 32'h0);
    rd(ces_pkg::STAT_OFS, 32'h7);
    ev(4'h8);
    rx_fault_count -= 1;
    rd(ces_pkg::STAT_OFS, 32'h10);
    ev(4'h9);
    tx_fault_count -= 1;
    rd(ces_pkg::STAT_OFS, 32'h18);
    wb(1'b1, ces_pkg::STAT_OFS, 32'h10);
    rd(ces_pkg::STAT_OFS, 32'h10);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, ces_pkg::ERRC_OFS, 32'hffff_ffff);
    rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, rx_fault_count));
    $display("test success done");
    // error irq only: warning crossing at 96
    wb(1'b1, ces_pkg::CTRL_OFS, 32'ha);
    tx_act <= 1'b1;
    repeat (9) ev(4'h4);
    chk({31'h0, irq_o}, 32'h0);
    ev(4'h4);
    tx_fault_count += 80;
    chk({31'h0, irq_o}, 32'h1);
    rd(ces_pkg::STAT_OFS, 32'h54);
    // passive entry at 128 gives no irq
    repeat (4) ev(4'h4);
    tx_fault_count += 32;
    chk({31'h0, irq_o}, 32'h0);
    rd(ces_pkg::STAT_OFS, 32'h74);
    rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, rx_fault_count));
    $display("test warning done");
    // receive counter up to the passive level and back
    tx_act <= 1'b0;
    repeat (125) ev(4'h1);
    rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, 127));
    ev(4'h1);
    rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, 128));
    ev(4'h8);
    rd(ces_pkg::ERRC_OFS, errc(tx_fault_count, 119));
    $display("test receive passive done");
    // bus-off, then recovery over three idle runs
    tx_act <= 1'b1;
    repeat (16) ev(4'h4);
    chk({31'h0, irq_o}, 32'h1);
    chk({31'h0, init_o}, 32'h1);
    wb(1'b0, ces_pkg::STAT_OFS, 32'h0);
    chk({31'h0, q[7]}, 32'h1);
    // bus-off, warning kept by the frozen count, rx ok, code 4
    chk({24'h0, q[7:0]}, 32'h0000_00d4);
    wb(1'b1, ces_pkg::CTRL_OFS, 32'ha);
    ev(4'ha);
    chk({31'h0, init_o}, 32'h0);
    wb(1'b0, ces_pkg::STAT_OFS, 32'h0);
    chk({29'h0, q[2:0]}, 32'h5);
    ev(4'ha);
    ev(4'ha);
    rd(ces_pkg::ERRC_OFS, 32'h0);
    rd(ces_pkg::STAT_OFS, 32'h15);
    $display("test bus-off done");
    // writes without the low lane leave control alone
    wsel = 4'he;
    wb(1'b1, ces_pkg::CTRL_OFS, 32'h0);
    wsel = 4'hf;
    rd(ces_pkg::CTRL_OFS, 32'ha);
    // mid-run reset returns control, status and counter registers to their reset values
    ev(4'h4);
    rd(ces_pkg::ERRC_OFS, errc(8, 0));
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk({31'h0, irq_o}, 32'h0);
    rd(ces_pkg::CTRL_OFS, {28'h0, ces_pkg::CTRL_RST});
    rd(ces_pkg::STAT_OFS, 32'h0);
    rd(ces_pkg::ERRC_OFS, ces_pkg::ERRC_RST);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : can_error_status_reporting_tb_top
